// *** pei_defs.svh ***
/*
 Register indices, field masks, reset values and thresholds for the
 PHY event status and enable block.
 Assumes it is included by bare name from the package and the design.
*/
`ifndef PEI_DEFS_SVH
`define PEI_DEFS_SVH

// Register indices; the byte address is four times the index
`define PEI_IDX_CTRL      6'h11
`define PEI_IDX_EVT1      6'h12
`define PEI_IDX_EVT2      6'h13
`define PEI_IDX_LSB       2

// Control register fields
`define PEI_CTRL_OE       0
`define PEI_CTRL_IEN      1
`define PEI_CTRL_TINT     2
`define PEI_CTRL_POL      3
`define PEI_CTRL_WMASK    16'h000f
`define PEI_CTRL_RST      16'h0008

// First event register
`define PEI_E1_LINK       13
`define PEI_E1_SPEED      12
`define PEI_E1_DUPLEX     11
`define PEI_E1_ANDONE     10
`define PEI_E1_FCHF       9
`define PEI_E1_REHF       8
`define PEI_E1_COR        16'h3f00
`define PEI_E1_WMASK      16'h003f

// Second event register
`define PEI_E2_ANERR      14
`define PEI_E2_PAGE       13
`define PEI_E2_LBFIFO     12
`define PEI_E2_XOVER      11
`define PEI_E2_SLEEP      10
`define PEI_E2_POLAR      9
`define PEI_E2_JABBER     8
`define PEI_E2_COR        16'h7e00
`define PEI_E2_WMASK      16'h007f

// Status bit n pairs with enable bit n minus this shift
`define PEI_EN_SHIFT      8
`define PEI_EN_RST        16'h0000
`define PEI_ST_RST        16'h0000

// Half-full thresholds of the error counters
`define PEI_FC_HALF       8'h7f
`define PEI_RE_HALF       16'h7fff

// Interrupt pin level while reset holds (polarity resets to one)
`define PEI_PIN_RST       1'h1

`endif

// *** pei_pkg.sv ***
/*
 Types shared by the PHY event status and enable block.
 Assumes pei_defs.svh is on the include path.
*/
`default_nettype none
`include "pei_defs.svh"

package pei_pkg;

   // One-cycle event pulses from the PHY core, jabber is a level
   typedef struct packed {
      logic link_chg;
      logic speed_chg;
      logic duplex_chg;
      logic an_done;
      logic an_error;
      logic page_rx;
      logic lb_fifo_fault;
      logic xover_chg;
      logic sleep_evt;
      logic polarity_chg;
      logic jabber_active;
   } pei_evt_t;

   typedef enum logic [1:0] {
      PEI_SEL_NONE,
      PEI_SEL_CTRL,
      PEI_SEL_EVT1,
      PEI_SEL_EVT2
   } pei_sel_t;

endpackage : pei_pkg

`default_nettype wire

// *** pei_event_irq.sv ***
/*
 PHY event status and enable registers with interrupt pin control,
 reached over an APB slave port.
 Assumes event pulses and counter values are synchronous to pclk and
 that the counters saturate and are cleared by their own logic.
*/
`default_nettype none
`include "pei_defs.svh"

// How it works
// RQ1: Duplex change sets bit 11, read clears.
// RQ2: Negotiation done sets bit 10, read clears.
// RQ3: False carrier half-full sets bit 9.
// RQ4: Receive error half-full sets bit 8.
// RQ5: Enables 5:0 of first register, reset zero.
// RQ6: Reserved bits read zero, writes dropped.
// RQ7: Status holds any event since last read.
// RQ8: Interrupt needs that event's enable bit.
// RQ9: Interrupt needs control bits one and zero.
// RQ10: Status latches regardless of any enable.
// RQ11: Negotiation error sets second bit 14.
// RQ12: Page received sets second bit 13.
// RQ13: Loopback FIFO fault sets second bit 12.
// RQ14: Crossover change sets second bit 11.
// RQ15: Sleep event sets second bit 10.
// RQ16: Polarity change sets second bit 9.
// RQ17: Jabber shows in bit 8, not read-cleared.
// RQ18: Enables 6:0 of second register, reset zero.
// RQ19: Link change bit 13, speed bit 12.
// RQ20: Bit 1 gates, bit 0 makes pin output.
// RQ21: Bit 3 picks pin idle level.
// RQ22: False carrier event above 7Fh count.
// RQ23: Event during clearing read stays latched.
// RQ24: Interrupt holds while enabled bits pending.
module pei_event_irq
   import pei_pkg::*;
#(
   parameter int FC_W = 8,
   parameter int RE_W = 16
) (
   input  wire logic            pclk,
   input  wire logic            presetn,
   input  wire logic            psel,
   input  wire logic            penable,
   input  wire logic            pwrite,
   input  wire logic [7:0]      paddr,
   input  wire logic [31:0]     pwdata,
   input  wire logic [3:0]      pstrb,
   output logic      [31:0]     prdata,
   output logic                 pready,
   output logic                 pslverr,
   input  wire pei_evt_t        evt,
   input  wire logic [FC_W-1:0] fc_count,
   input  wire logic [RE_W-1:0] re_count,
   input  wire logic            irq_pin_i,
   output logic                 irq_pin_o,
   output logic                 irq_pin_oe,
   output logic                 powerdown_req,
   output logic                 irq_active
);

   logic [15:0] ctrl_ff;
   logic [15:0] en1_ff;
   logic [15:0] en2_ff;
   logic [15:0] st1_ff;
   logic [15:0] st2_ff;
   logic [15:0] snap_ff;
   logic [31:0] prdata_ff;
   logic        fc_hi_ff;
   logic        re_hi_ff;
   logic        active_ff;
   logic        pin_ff;

   pei_sel_t    sel;
   logic        setup_ph;
   logic        access_ph;
   logic        wr_done;
   logic        rd_done;
   logic [15:0] wdata16;
   logic [15:0] lane_mask;
   logic [15:0] rd_evt1;
   logic [15:0] rd_evt2;
   logic [15:0] rd_mux;
   logic        fc_hi;
   logic        re_hi;
   logic        fc_evt;
   logic        re_evt;
   logic [15:0] set1;
   logic [15:0] set2;
   logic [15:0] clr1;
   logic [15:0] clr2;
   logic [15:0] nxt_st1;
   logic [15:0] nxt_st2;
   logic [15:0] live2;
   logic [7:0]  hit1;
   logic [7:0]  hit2;
   logic        pending;
   logic        nxt_active;
   logic        nxt_pin;

   // Bus phases and address decode
   assign setup_ph  = psel & ~penable;
   assign access_ph = psel & penable;
   assign wr_done   = access_ph & pwrite;
   assign rd_done   = access_ph & ~pwrite;

   always_comb begin
      sel = PEI_SEL_NONE;
      if (paddr[1:0] == 2'h0) begin
         if (paddr[7:`PEI_IDX_LSB] == `PEI_IDX_CTRL) begin
            sel = PEI_SEL_CTRL;
         end else if (paddr[7:`PEI_IDX_LSB] == `PEI_IDX_EVT1) begin
            sel = PEI_SEL_EVT1;
         end else if (paddr[7:`PEI_IDX_LSB] == `PEI_IDX_EVT2) begin
            sel = PEI_SEL_EVT2;
         end
      end
   end

   // Zero wait states; read data was captured during setup
   assign pready  = access_ph;
   assign pslverr = access_ph & (sel == PEI_SEL_NONE);
   assign prdata  = prdata_ff;

   // Byte enables apply to the two low lanes only
   assign lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
   assign wdata16   = pwdata[15:0];

   // Counter threshold crossing
   // RQ22: above half mark
   assign fc_hi  = (fc_count > FC_W'(`PEI_FC_HALF));
   assign re_hi  = (re_count > RE_W'(`PEI_RE_HALF));
   // RQ3: rising crossing only
   assign fc_evt = fc_hi & ~fc_hi_ff;
   // RQ4: rising crossing only
   assign re_evt = re_hi & ~re_hi_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fc_hi_ff <= 1'h0;
         re_hi_ff <= 1'h0;
      end else begin
         fc_hi_ff <= fc_hi;
         re_hi_ff <= re_hi;
      end
   end

   // Event set vectors, placed at their status positions
   always_comb begin
      set1 = `PEI_ST_RST;
      // RQ19: link and speed
      set1[`PEI_E1_LINK]   = evt.link_chg;
      set1[`PEI_E1_SPEED]  = evt.speed_chg;
      // RQ1: duplex change
      set1[`PEI_E1_DUPLEX] = evt.duplex_chg;
      // RQ2: negotiation done
      set1[`PEI_E1_ANDONE] = evt.an_done;
      set1[`PEI_E1_FCHF]   = fc_evt;
      set1[`PEI_E1_REHF]   = re_evt;
   end

   always_comb begin
      set2 = `PEI_ST_RST;
      // RQ11: negotiation error
      set2[`PEI_E2_ANERR]  = evt.an_error;
      // RQ12: page received
      set2[`PEI_E2_PAGE]   = evt.page_rx;
      // RQ13: loopback FIFO fault
      set2[`PEI_E2_LBFIFO] = evt.lb_fifo_fault;
      // RQ14: crossover state change
      set2[`PEI_E2_XOVER]  = evt.xover_chg;
      // RQ15: sleep mode event
      set2[`PEI_E2_SLEEP]  = evt.sleep_evt;
      // RQ16: polarity change
      set2[`PEI_E2_POLAR]  = evt.polarity_chg;
   end

   // Jabber is not latched; it follows the detector
   always_comb begin
      live2 = `PEI_ST_RST;
      // RQ17: live jabber bit
      live2[`PEI_E2_JABBER] = evt.jabber_active;
   end

   // A read clears only the bits it actually returned, so an event
   // landing between setup and access is reported on the next read.
   // RQ23: clear only snapshot
   assign clr1 = (rd_done && sel == PEI_SEL_EVT1) ?
                 (snap_ff & `PEI_E1_COR) : `PEI_ST_RST;
   assign clr2 = (rd_done && sel == PEI_SEL_EVT2) ?
                 (snap_ff & `PEI_E2_COR) : `PEI_ST_RST;

   // Set wins over clear, independent of any enable
   // RQ7: sticky since last read
   // RQ10: enables not consulted
   // RQ23: set beats clear
   assign nxt_st1 = ((st1_ff & ~clr1) | set1) & `PEI_E1_COR;
   assign nxt_st2 = ((st2_ff & ~clr2) | set2) & `PEI_E2_COR;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st1_ff <= `PEI_ST_RST;
      end else begin
         st1_ff <= nxt_st1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st2_ff <= `PEI_ST_RST;
      end else begin
         st2_ff <= nxt_st2;
      end
   end

   // Enable halves of the event registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en1_ff <= `PEI_EN_RST;
      end else if (wr_done && sel == PEI_SEL_EVT1) begin
         // RQ5: writable enables only
         en1_ff <= ((en1_ff & ~lane_mask) | (wdata16 & lane_mask))
                   & `PEI_E1_WMASK;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en2_ff <= `PEI_EN_RST;
      end else if (wr_done && sel == PEI_SEL_EVT2) begin
         // RQ18: writable enables only
         en2_ff <= ((en2_ff & ~lane_mask) | (wdata16 & lane_mask))
                   & `PEI_E2_WMASK;
      end
   end

   // Control register: output enable, gate, test and polarity
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_ff <= `PEI_CTRL_RST;
      end else if (wr_done && sel == PEI_SEL_CTRL) begin
         ctrl_ff <= ((ctrl_ff & ~lane_mask) | (wdata16 & lane_mask))
                    & `PEI_CTRL_WMASK;
      end
   end

   // Read views; reserved positions are zero by the masks
   // RQ6: reserved bits zero
   assign rd_evt1 = (st1_ff & `PEI_E1_COR) | (en1_ff & `PEI_E1_WMASK);
   assign rd_evt2 = (st2_ff & `PEI_E2_COR) | live2
                  | (en2_ff & `PEI_E2_WMASK);

   always_comb begin
      unique case (sel)
         PEI_SEL_CTRL: rd_mux = ctrl_ff & `PEI_CTRL_WMASK;
         PEI_SEL_EVT1: rd_mux = rd_evt1;
         PEI_SEL_EVT2: rd_mux = rd_evt2;
         PEI_SEL_NONE: rd_mux = `PEI_ST_RST;
      endcase
   end

   // Capture read data at the end of setup; snapshot drives clearing
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= 32'h0000_0000;
         snap_ff   <= `PEI_ST_RST;
      end else if (setup_ph && !pwrite) begin
         prdata_ff <= {16'h0000, rd_mux};
         snap_ff   <= rd_mux;
      end
   end

   // Pending status with enable; jabber counts while it is present
   // RQ8: per-event enable
   assign hit1 = st1_ff[15:`PEI_EN_SHIFT] & en1_ff[7:0];
   assign hit2 = (st2_ff[15:`PEI_EN_SHIFT] | live2[15:`PEI_EN_SHIFT])
               & en2_ff[7:0];
   assign pending = (|hit1) | (|hit2);

   // RQ9: both control gates
   // RQ20: gate and output enable
   // RQ24: level while pending
   assign nxt_active = ctrl_ff[`PEI_CTRL_IEN] & ctrl_ff[`PEI_CTRL_OE]
                     & (pending | ctrl_ff[`PEI_CTRL_TINT]);

   // RQ21: polarity one idles high
   assign nxt_pin = ctrl_ff[`PEI_CTRL_POL] ? ~nxt_active : nxt_active;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         active_ff <= 1'h0;
         pin_ff    <= `PEI_PIN_RST;
      end else begin
         active_ff <= nxt_active;
         pin_ff    <= nxt_pin;
      end
   end

   assign irq_active = active_ff;
   assign irq_pin_o  = pin_ff;

   // When not an output the shared pin is an active-low power-down
   // request; it is sampled as is, since inputs are pclk-synchronous.
   // RQ20: pin role select
   assign irq_pin_oe    = ctrl_ff[`PEI_CTRL_OE];
   assign powerdown_req = ~ctrl_ff[`PEI_CTRL_OE] & ~irq_pin_i;

endmodule : pei_event_irq

`default_nettype wire

// *** pei_host.sv ***
/*
 APB master standing in for the management host.
 Assumes a zero or more wait-state slave sharing pclk.
*/
`default_nettype none
module pei_host (
   input  wire logic        pclk,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [7:0]       paddr,
   output logic [31:0]      pwdata,
   output logic [3:0]       pstrb,
   input  wire logic        pready,
   input  wire logic [31:0] prdata
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      pstrb = 4'hf;
   end
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
             output logic [31:0] q);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      pstrb <= s;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      q = prdata;
      psel <= 1'h0;
      penable <= 1'h0;
      // Released address and data lines flip so stale values never look valid
      paddr <= ~a;
      pwdata <= ~d;
   endtask : xfer
endmodule : pei_host
`default_nettype wire

// *** pei_assertions.sv ***
/*
 Port-level checker for pei_event_irq.
 Assumes it is bound into every instance of that module.
*/
`default_nettype none
module pei_chk
   import pei_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire pei_evt_t    evt,
   input wire logic        irq_pin_oe,
   input wire logic        irq_active
);
   timeunit 1ns;
   timeprecision 1ps;
   logic mapped;
   logic rs;
   assign mapped = paddr inside {8'h44, 8'h48, 8'h4c};
   assign rs = psel && !penable && !pwrite;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_ready; psel && penable && mapped |-> pready && !pslverr; endproperty
   a_ready: assert property (p_ready) else $error("mapped access refused");
   property p_unmap; psel && penable && !mapped |-> pready && pslverr; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped access not flagged");
   property p_undata; rs && !mapped |=> prdata == 32'h0; endproperty
   a_undata: assert property (p_undata) else $error("unmapped read not zero");
   property p_hi; rs |=> prdata[31:16] == 16'h0000; endproperty
   a_hi: assert property (p_hi) else $error("upper read half not zero");
   property p_rsv1; rs && paddr == 8'h48 |=> prdata[15:14] == 2'h0 && prdata[7:6] == 2'h0;
   endproperty
   a_rsv1: assert property (p_rsv1) else $error("first register reserved bits set");
   property p_rsv2; rs && paddr == 8'h4c |=> !prdata[15] && !prdata[7]; endproperty
   a_rsv2: assert property (p_rsv2) else $error("second register reserved bits set");
   property p_jab;
      rs && paddr == 8'h4c && $stable(evt.jabber_active) |=> prdata[8] == $past(evt.jabber_active);
   endproperty
   a_jab: assert property (p_jab) else $error("jabber bit not live");
   property p_hold; !rs |=> $stable(prdata); endproperty
   a_hold: assert property (p_hold) else $error("read data changed without read");
   property p_gate; !irq_pin_oe && !$past(irq_pin_oe) |-> !irq_active; endproperty
   a_gate: assert property (p_gate) else $error("interrupt with output disabled");
endmodule : pei_chk
bind pei_event_irq pei_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata,
   .pready, .pslverr, .evt, .irq_pin_oe, .irq_active);
`default_nettype wire

// *** testbench.sv ***
/*
 Self-checking bench for pei_event_irq with an APB host model.
 Assumes pei_host and the bound checker are compiled first.
*/
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import pei_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        irq_pin_i, irq_pin_o, irq_pin_oe, powerdown_req, irq_active;
   logic [7:0]  paddr, fc;
   logic [3:0]  pstrb;
   logic [15:0] re;
   logic [31:0] pwdata, prdata, q;
   pei_evt_t    evt;
   int          fail_count, checks;
   pei_event_irq u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
      .prdata, .pready, .pslverr, .evt, .fc_count(fc), .re_count(re), .irq_pin_i, .irq_pin_o,
      .irq_pin_oe, .powerdown_req, .irq_active);
   pei_host u_host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata);
   initial begin
      pclk = 1'h0;
      forever #10 pclk = ~pclk;
   end
   task test_done;
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : test_done
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task rd(input logic [7:0] a, input logic [31:0] e);
      u_host.xfer(1'h0, a, 32'h0, 4'hf, q);
      chk($sformatf("read %h", a), e, q);
   endtask : rd
   task wr(input logic [7:0] a, input logic [31:0] d);
      u_host.xfer(1'h1, a, d, 4'hf, q);
   endtask : wr
   task wt(input int n);
      repeat (n) @(posedge pclk);
   endtask : wt
   task pulse(input pei_evt_t v);
      @(posedge pclk);
      evt <= v;
      @(posedge pclk);
      evt <= '0;
   endtask : pulse
   task t_regs;
      rd(8'h44, 32'h8);
      rd(8'h48, 32'h0);
      rd(8'h4c, 32'h0);
      wr(8'h48, 32'hffff);
      rd(8'h48, 32'h3f);
      wr(8'h4c, 32'hffff);
      rd(8'h4c, 32'h7f);
      // Low lane strobe off leaves the enables untouched
      u_host.xfer(1'h1, 8'h4c, 32'h0, 4'he, q);
      rd(8'h4c, 32'h7f);
      wr(8'h48, 32'h0);
      wr(8'h4c, 32'h0);
      wr(8'h50, 32'hffff);
      rd(8'h50, 32'h0);
      rd(8'h46, 32'h0);
      rd(8'h44, 32'h8);
   endtask : t_regs
   task t_events;
      logic [7:0] a;
      for (int i = 1; i < 11; i++) begin
         pulse(11'h1 << i);
         a = (i > 6) ? 8'h48 : 8'h4c;
         rd(a, 32'h1 << ((i > 6) ? i + 3 : i + 8));
         rd(a, 32'h0);
      end
   endtask : t_events
   // Event lands at the snapshot edge, so the clearing read must spare it
   task t_race;
      fork
         u_host.xfer(1'h0, 8'h48, 32'h0, 4'hf, q);
         begin
            @(posedge pclk);
            evt <= 11'h100;
            @(posedge pclk);
            evt <= '0;
         end
      join
      chk("read 48 during event", 32'h0, q);
      rd(8'h48, 32'h800);
      rd(8'h48, 32'h0);
   endtask : t_race
   task t_counts;
      fc <= 8'h7f;
      re <= 16'h7fff;
      wt(2);
      rd(8'h48, 32'h0);
      fc <= 8'h80;
      re <= 16'h8000;
      wt(2);
      rd(8'h48, 32'h300);
      rd(8'h48, 32'h0);
      evt <= 11'h1;
      wt(2);
      rd(8'h4c, 32'h100);
      rd(8'h4c, 32'h100);
      evt <= '0;
      wt(2);
      rd(8'h4c, 32'h0);
   endtask : t_counts
   task t_irq;
      wr(8'h44, 32'hb);
      wr(8'h48, 32'h8);
      pulse(11'h200);
      wt(2);
      chk("irq_active", 1'h0, irq_active);
      rd(8'h48, 32'h1008);
      pulse(11'h100);
      wt(2);
      chk("irq_active", 1'h1, irq_active);
      chk("irq_pin_o", 1'h0, irq_pin_o);
      chk("irq_pin_oe", 1'h1, irq_pin_oe);
      wr(8'h44, 32'h9);
      wt(2);
      chk("irq_active", 1'h0, irq_active);
      wr(8'h44, 32'h3);
      wt(2);
      chk("irq_active", 1'h1, irq_active);
      chk("irq_pin_o", 1'h1, irq_pin_o);
      rd(8'h48, 32'h808);
      wt(2);
      chk("irq_active", 1'h0, irq_active);
      chk("irq_pin_o", 1'h0, irq_pin_o);
      wr(8'h44, 32'h7);
      wt(2);
      chk("irq_active", 1'h1, irq_active);
      chk("irq_pin_o", 1'h1, irq_pin_o);
      wr(8'h44, 32'h8);
      irq_pin_i <= 1'h0;
      wt(2);
      chk("powerdown_req", 1'h1, powerdown_req);
      chk("irq_pin_oe", 1'h0, irq_pin_oe);
      irq_pin_i <= 1'h1;
   endtask : t_irq
   initial begin
      presetn = 1'h0;
      irq_pin_i = 1'h1;
      evt = '0;
      fc = 8'h00;
      re = 16'h0000;
      repeat (5) @(posedge pclk);
      presetn <= 1'h1;
      t_regs();
      t_events();
      t_race();
      t_counts();
      t_irq();
      test_done();
   end
   // Whole run is a few hundred cycles; this margin only catches a hang
   initial begin
      repeat (3000) @(posedge pclk);
      fail_count++;
      $display("BAD watchdog expected finish seen hang");
      test_done();
   end
endmodule : testbench
`default_nettype wire
